/* File: include/mpc_pkg.sv */
// Purpose: Shared constants and types for the multi-purpose command block
// Assumes: Command pins are sampled by pclk; the link clock is slow beside it
// Notes: Register offsets are byte addresses on a 32-bit APB
`default_nettype none
package mpc_pkg;
  // Training FIFO shape
  localparam int FIFO_DEPTH = 5;
  localparam int PTR_W = 3;
  localparam int BEATS = 16;
  localparam int DQ_W = 8;
  localparam int ENTRY_W = BEATS * DQ_W;
  localparam int LAT_W = 6;
  localparam int LAT_MAX = 64;
  // Training transfers always run 16 beats
  localparam logic [4:0] TRAIN_BEATS = 5'h10;
  // Operand codes of the training functions
  localparam logic [6:0] OP_RD_FIFO = 7'h41;
  localparam logic [6:0] OP_RD_CAL = 7'h43;
  localparam logic [6:0] OP_WR_FIFO = 7'h47;
  localparam logic [6:0] OP_OSC_START = 7'h4b;
  localparam logic [6:0] OP_OSC_STOP = 7'h4d;
  localparam logic [6:0] OP_ZQ_START = 7'h4f;
  localparam logic [6:0] OP_ZQ_LATCH = 7'h51;
  // First-edge codes on cmd_addr_bus[4:0], bit 0 is the lowest pin
  localparam logic [4:0] CA_MPC = 5'h00;
  localparam logic [4:0] CA_CAS2 = 5'h12;
  localparam logic [4:0] CA_WR1 = 5'h04;
  localparam logic [4:0] CA_MWR = 5'h0c;
  localparam logic [4:0] CA_RD1 = 5'h02;
  localparam logic [4:0] CA_MRR = 5'h0e;
  // Register offsets
  localparam logic [11:0] ADDR_CFG = 12'h000;
  localparam logic [11:0] ADDR_PAT = 12'h004;
  localparam logic [11:0] ADDR_OSC = 12'h008;
  localparam logic [11:0] ADDR_STAT = 12'h00c;
  // Field positions
  localparam int CFG_RL_LSB = 0;
  localparam int CFG_WL_LSB = 8;
  localparam int CFG_WDBI_BIT = 16;
  localparam int CFG_RDBI_BIT = 17;
  localparam int CFG_DM_BIT = 18;
  localparam int STAT_WPTR_LSB = 0;
  localparam int STAT_RPTR_LSB = 4;
  localparam int STAT_PERR_BIT = 8;
  localparam int STAT_ZQ_BIT = 9;
  localparam int STAT_OSC_BIT = 10;
  // Reset values
  localparam logic [31:0] CFG_RESET = 32'h0000080e;
  localparam logic [15:0] PAT_RESET = 16'h0000;
  // Sampled command pins travel together
  typedef struct packed {
    logic ck;
    logic cke;
    logic cs;
    logic [5:0] ca;
  } pins_s;
  // Command sequencer states, Gray along the path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OP = 2'b01,
    ST_CAS1 = 2'b11,
    ST_CAS2 = 2'b10
  } cmd_state_e;
  // Kind of training transfer waiting for its column follow-up
  typedef enum logic [1:0] {
    K_NONE = 2'b00,
    K_RD_FIFO = 2'b01,
    K_RD_CAL = 2'b10,
    K_WR_FIFO = 2'b11
  } train_kind_e;
endpackage : mpc_pkg
`default_nettype wire

/* File: design/train_fifo_mem.sv */
// Purpose: Storage array of the training FIFO
// Assumes: One write and one read port on pclk
// Notes: Read data is registered every cycle from the read address
`timescale 1ns/1ns
`default_nettype none
module train_fifo_mem #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 5,
  parameter int AW = 3
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata_r
);
  // Entries are not reset, so unwritten ones read undefined
  logic [WIDTH-1:0] mem [DEPTH];

  // Write and registered read
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end
endmodule : train_fifo_mem
`default_nettype wire

/* File: design/multi_purpose_training_command.sv */
// Purpose: Decode multi-purpose commands and run the training FIFO path
// Assumes: Link pins are asynchronous to pclk and far slower than it
// Notes: Latencies are counted in link clock rising edges
`timescale 1ns/1ns
`default_nettype none
module multi_purpose_training_command #(
  parameter int ENTRY_W = mpc_pkg::ENTRY_W
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command pins from the controller
  input wire logic ck_pin,
  input wire logic cke_pin,
  input wire logic cs_pin,
  input wire logic [5:0] cmd_addr_bus,
  // Oscillator and calibration engines
  input wire logic [15:0] osc_count,
  input wire logic zq_busy,
  output logic osc_start,
  output logic osc_stop,
  output logic zq_start,
  output logic zq_latch,
  // Training datapath
  input wire logic [ENTRY_W-1:0] fifo_wr_data,
  output logic wr_capture,
  output logic rd_launch,
  output logic rd_is_calib,
  output logic mask_inversion_drive,
  output logic [ENTRY_W-1:0] rd_burst_data,
  output logic [4:0] burst_beats
);
  localparam int PW = mpc_pkg::PTR_W;
  localparam int LM = mpc_pkg::LAT_MAX;

  // Pin synchroniser stages and link clock history
  mpc_pkg::pins_s sync1_r, sync2_r;
  logic ck_d_r;
  // Command sequencer
  mpc_pkg::cmd_state_e st_r, st_nxt;
  mpc_pkg::train_kind_e kind_r, kind_nxt;
  logic op6_r, op6_nxt;
  // Latency pipes, one bit per link clock edge
  logic [LM-1:0] wr_pipe_r, wr_pipe_nxt, rd_pipe_r, rd_pipe_nxt, cal_pipe_r, cal_pipe_nxt;
  // FIFO pointers
  logic [PW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  // Registered outputs
  logic osc_start_r, osc_start_nxt, osc_stop_r, osc_stop_nxt;
  logic zq_start_r, zq_start_nxt, zq_latch_r, zq_latch_nxt;
  logic wr_cap_r, wr_cap_nxt, rd_launch_r, rd_launch_nxt, calib_r, calib_nxt;
  logic dmi_r, dmi_nxt;
  logic [ENTRY_W-1:0] rd_data_r, rd_data_nxt, mem_q, cal_word;
  // Software state
  logic [31:0] cfg_r, cfg_nxt, prdata_r, prdata_nxt;
  logic [15:0] pat_r, pat_nxt, osc_cnt_r, osc_cnt_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic pair_err_r, pair_err_nxt, osc_run_r, osc_run_nxt;
  // Decode helpers
  logic ck_rise, op_take, disturb, mem_we;
  logic [6:0] op_val;
  logic [mpc_pkg::LAT_W-1:0] rl, wl;

  assign rl = cfg_r[mpc_pkg::CFG_RL_LSB +: mpc_pkg::LAT_W];
  assign wl = cfg_r[mpc_pkg::CFG_WL_LSB +: mpc_pkg::LAT_W];

  // Two-stage synchroniser; only the second stage feeds logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      ck_d_r <= 1'b0;
    end else begin
      sync1_r <= {ck_pin, cke_pin, cs_pin, cmd_addr_bus};
      sync2_r <= sync1_r;
      ck_d_r <= sync2_r.ck;
    end
  end

  // Rising link clock edge as a one-cycle enable
  assign ck_rise = sync2_r.ck & ~ck_d_r;

  // Pattern burst: beat b on every pin is pattern bit b, low byte first
  for (genvar b = 0; b < mpc_pkg::BEATS; b++) begin : g_cal
    assign cal_word[b*mpc_pkg::DQ_W +: mpc_pkg::DQ_W] = {mpc_pkg::DQ_W{pat_r[b]}};
  end

  // Command decode, latency pipes and FIFO pointers
  always_comb begin
    st_nxt = st_r;
    kind_nxt = kind_r;
    op6_nxt = op6_r;
    wr_pipe_nxt = wr_pipe_r;
    rd_pipe_nxt = rd_pipe_r;
    cal_pipe_nxt = cal_pipe_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    osc_start_nxt = 1'b0;
    osc_stop_nxt = 1'b0;
    zq_start_nxt = 1'b0;
    zq_latch_nxt = 1'b0;
    wr_cap_nxt = 1'b0;
    rd_launch_nxt = 1'b0;
    calib_nxt = calib_r;
    dmi_nxt = 1'b0;
    rd_data_nxt = rd_data_r;
    osc_cnt_nxt = osc_cnt_r;
    osc_run_nxt = osc_run_r;
    op_take = 1'b0;
    disturb = 1'b0;
    mem_we = 1'b0;
    op_val = {op6_r, sync2_r.ca};
    if (ck_rise) begin
      // Latency advances one step per link edge
      wr_pipe_nxt = {wr_pipe_r[LM-2:0], 1'b0};
      rd_pipe_nxt = {rd_pipe_r[LM-2:0], 1'b0};
      cal_pipe_nxt = {cal_pipe_r[LM-2:0], 1'b0};
      unique case (st_r)
        mpc_pkg::ST_IDLE: begin
          // Bank and refresh state does not gate acceptance
          if (sync2_r.cke && sync2_r.cs) begin
            if (sync2_r.ca[4:0] == mpc_pkg::CA_MPC) begin
              op6_nxt = sync2_r.ca[5];
              st_nxt = mpc_pkg::ST_OP;
            end else if (sync2_r.ca[4:0] == mpc_pkg::CA_WR1 ||
                         sync2_r.ca[4:0] == mpc_pkg::CA_MWR ||
                         sync2_r.ca[4:0] == mpc_pkg::CA_RD1 ||
                         sync2_r.ca[4:0] == mpc_pkg::CA_MRR) begin
              disturb = 1'b1;
            end
          end
        end
        mpc_pkg::ST_OP: begin
          // Second edge carries the low six operand bits
          op_take = 1'b1;
          st_nxt = mpc_pkg::ST_IDLE;
          if (op6_r) begin
            case (op_val)
              mpc_pkg::OP_RD_FIFO: begin
                kind_nxt = mpc_pkg::K_RD_FIFO;
                st_nxt = mpc_pkg::ST_CAS1;
              end
              mpc_pkg::OP_RD_CAL: begin
                kind_nxt = mpc_pkg::K_RD_CAL;
                st_nxt = mpc_pkg::ST_CAS1;
              end
              mpc_pkg::OP_WR_FIFO: begin
                kind_nxt = mpc_pkg::K_WR_FIFO;
                st_nxt = mpc_pkg::ST_CAS1;
              end
              // Complete on their own, no follow-up wait
              mpc_pkg::OP_OSC_START: begin
                osc_start_nxt = 1'b1;
                osc_run_nxt = 1'b1;
              end
              mpc_pkg::OP_OSC_STOP: begin
                osc_stop_nxt = 1'b1;
                osc_run_nxt = 1'b0;
                osc_cnt_nxt = osc_count;
              end
              mpc_pkg::OP_ZQ_START: begin
                zq_start_nxt = ~zq_busy;
              end
              mpc_pkg::OP_ZQ_LATCH: begin
                zq_latch_nxt = 1'b1;
              end
              // Reserved codes leave every state alone
              default: begin
                st_nxt = mpc_pkg::ST_IDLE;
              end
            endcase
          end
        end
        mpc_pkg::ST_CAS1: begin
          // The follow-up must come at once; otherwise drop the transfer
          if (sync2_r.cke && sync2_r.cs && sync2_r.ca[4:0] == mpc_pkg::CA_CAS2) begin
            st_nxt = mpc_pkg::ST_CAS2;
          end else begin
            // Pairing flag itself is kept by the register process
            kind_nxt = mpc_pkg::K_NONE;
            st_nxt = mpc_pkg::ST_IDLE;
          end
        end
        mpc_pkg::ST_CAS2: begin
          // Latency starts at this edge; back to idle for seamless repeats
          st_nxt = mpc_pkg::ST_IDLE;
          kind_nxt = mpc_pkg::K_NONE;
          wr_pipe_nxt[0] = (kind_r == mpc_pkg::K_WR_FIFO);
          rd_pipe_nxt[0] = (kind_r == mpc_pkg::K_RD_FIFO);
          cal_pipe_nxt[0] = (kind_r == mpc_pkg::K_RD_CAL);
          disturb = (kind_r == mpc_pkg::K_RD_CAL);
        end
      endcase
      // Write data captured at write latency
      if (wr_pipe_nxt[wl]) begin
        wr_cap_nxt = 1'b1;
        mem_we = 1'b1;
        wr_ptr_nxt = (wr_ptr_r == PW'(mpc_pkg::FIFO_DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      // FIFO read returned at read latency
      if (rd_pipe_nxt[rl]) begin
        rd_launch_nxt = 1'b1;
        calib_nxt = 1'b0;
        rd_data_nxt = mem_q;
        dmi_nxt = cfg_r[mpc_pkg::CFG_WDBI_BIT] | cfg_r[mpc_pkg::CFG_RDBI_BIT] |
                  cfg_r[mpc_pkg::CFG_DM_BIT];
        rd_ptr_nxt = (rd_ptr_r == PW'(mpc_pkg::FIFO_DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end else if (cal_pipe_nxt[rl]) begin
        rd_launch_nxt = 1'b1;
        calib_nxt = 1'b1;
        rd_data_nxt = cal_word;
      end
      // Clock enable low also disturbs and abandons a command
      if (!sync2_r.cke) begin
        disturb = 1'b1;
        st_nxt = mpc_pkg::ST_IDLE;
      end
      if (disturb) begin
        wr_ptr_nxt = '0;
        rd_ptr_nxt = '0;
      end
    end
  end

  // Sequencer and datapath registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= mpc_pkg::ST_IDLE;
      kind_r <= mpc_pkg::K_NONE;
      op6_r <= 1'b0;
      wr_pipe_r <= '0;
      rd_pipe_r <= '0;
      cal_pipe_r <= '0;
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      osc_start_r <= 1'b0;
      osc_stop_r <= 1'b0;
      zq_start_r <= 1'b0;
      zq_latch_r <= 1'b0;
      wr_cap_r <= 1'b0;
      rd_launch_r <= 1'b0;
      calib_r <= 1'b0;
      dmi_r <= 1'b0;
      rd_data_r <= '0;
      osc_cnt_r <= '0;
      osc_run_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      op6_r <= op6_nxt;
      wr_pipe_r <= wr_pipe_nxt;
      rd_pipe_r <= rd_pipe_nxt;
      cal_pipe_r <= cal_pipe_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      osc_start_r <= osc_start_nxt;
      osc_stop_r <= osc_stop_nxt;
      zq_start_r <= zq_start_nxt;
      zq_latch_r <= zq_latch_nxt;
      wr_cap_r <= wr_cap_nxt;
      rd_launch_r <= rd_launch_nxt;
      calib_r <= calib_nxt;
      dmi_r <= dmi_nxt;
      rd_data_r <= rd_data_nxt;
      osc_cnt_r <= osc_cnt_nxt;
      osc_run_r <= osc_run_nxt;
    end
  end

  // Five-entry training storage
  train_fifo_mem #(.WIDTH(ENTRY_W), .DEPTH(mpc_pkg::FIFO_DEPTH), .AW(PW)) u_mem (
    .clk(pclk),
    .we(mem_we),
    .waddr(wr_ptr_r),
    .wdata(fifo_wr_data),
    .raddr(rd_ptr_r),
    .rdata_r(mem_q)
  );

  // APB decode; answer comes in the first access cycle
  always_comb begin
    cfg_nxt = cfg_r;
    pat_nxt = pat_r;
    pready_nxt = psel & ~penable;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    // Pairing error: hardware set wins over write-one clear
    pair_err_nxt = pair_err_r;
    if (psel && !penable) begin
      prdata_nxt = '0;
      case (paddr)
        mpc_pkg::ADDR_CFG: prdata_nxt = cfg_r;
        mpc_pkg::ADDR_PAT: prdata_nxt = {16'h0000, pat_r};
        mpc_pkg::ADDR_OSC: prdata_nxt = {16'h0000, osc_cnt_r};
        mpc_pkg::ADDR_STAT: begin
          prdata_nxt[mpc_pkg::STAT_WPTR_LSB +: PW] = wr_ptr_r;
          prdata_nxt[mpc_pkg::STAT_RPTR_LSB +: PW] = rd_ptr_r;
          prdata_nxt[mpc_pkg::STAT_PERR_BIT] = pair_err_r;
          prdata_nxt[mpc_pkg::STAT_ZQ_BIT] = zq_busy;
          prdata_nxt[mpc_pkg::STAT_OSC_BIT] = osc_run_r;
        end
        default: pslverr_nxt = 1'b1;
      endcase
    end
    if (psel && penable && pready_r && pwrite) begin
      if (paddr == mpc_pkg::ADDR_CFG) cfg_nxt = pwdata;
      if (paddr == mpc_pkg::ADDR_PAT) pat_nxt = pwdata[15:0];
      if (paddr == mpc_pkg::ADDR_STAT && pwdata[mpc_pkg::STAT_PERR_BIT]) pair_err_nxt = 1'b0;
    end
    if (ck_rise && st_r == mpc_pkg::ST_CAS1 &&
        !(sync2_r.cke && sync2_r.cs && sync2_r.ca[4:0] == mpc_pkg::CA_CAS2)) begin
      pair_err_nxt = 1'b1;
    end
  end

  // Software-visible registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= mpc_pkg::CFG_RESET;
      pat_r <= mpc_pkg::PAT_RESET;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      pair_err_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      pat_r <= pat_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      pair_err_r <= pair_err_nxt;
    end
  end

  // Outputs straight from flops except burst_beats, a constant; transfers are fixed at 16 beats
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign osc_start = osc_start_r;
  assign osc_stop = osc_stop_r;
  assign zq_start = zq_start_r;
  assign zq_latch = zq_latch_r;
  assign wr_capture = wr_cap_r;
  assign rd_launch = rd_launch_r;
  assign rd_is_calib = calib_r;
  assign mask_inversion_drive = dmi_r;
  assign rd_burst_data = rd_data_r;
  assign burst_beats = mpc_pkg::TRAIN_BEATS;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_train_op;
    op_take && op6_r && (op_val == mpc_pkg::OP_WR_FIFO || op_val == mpc_pkg::OP_RD_FIFO);
  endsequence
  sequence s_no_follow;
    ck_rise && st_r == mpc_pkg::ST_CAS1 && !(sync2_r.cs && sync2_r.ca[4:0] == mpc_pkg::CA_CAS2);
  endsequence

  property p_nop;
    op_take && !op6_r |=> !osc_start && !osc_stop && !zq_start && !zq_latch && st_r == mpc_pkg::ST_IDLE;
  endproperty
  a_nop: assert property (p_nop) else $error("nop had an effect");
  property p_train_waits;
    s_train_op |=> st_r == mpc_pkg::ST_CAS1;
  endproperty
  a_train_waits: assert property (p_train_waits) else $error("transfer not awaiting follow-up");
  property p_osc_start;
    op_take && op_val == mpc_pkg::OP_OSC_START |=> osc_start ##1 !osc_start;
  endproperty
  a_osc_start: assert property (p_osc_start) else $error("oscillator start missing");
  property p_osc_capture;
    op_take && op_val == mpc_pkg::OP_OSC_STOP |=> osc_stop && osc_cnt_r == $past(osc_count);
  endproperty
  a_osc_capture: assert property (p_osc_capture) else $error("count not captured");
  property p_zq_busy;
    op_take && op_val == mpc_pkg::OP_ZQ_START && zq_busy |=> !zq_start;
  endproperty
  a_zq_busy: assert property (p_zq_busy) else $error("start while calibrating");
  property p_reserved;
    op_take && op6_r && op_val == 7'h45 && !mem_we && !rd_launch_nxt && !disturb |=>
      $stable(wr_ptr_r) && $stable(rd_ptr_r) && !osc_start;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code acted");
  property p_ptr_range;
    wr_ptr_r < 3'h5 && rd_ptr_r < 3'h5;
  endproperty
  a_ptr_range: assert property (p_ptr_range) else $error("pointer out of range");
  property p_rd_wrap;
    rd_launch_nxt && !calib_nxt && !disturb && rd_ptr_r == 3'h4 |=> rd_ptr_r == 3'h0 && rd_launch;
  endproperty
  a_rd_wrap: assert property (p_rd_wrap) else $error("read pointer did not wrap");
  property p_disturb;
    ck_rise && !sync2_r.cke |=> wr_ptr_r == 3'h0 && rd_ptr_r == 3'h0;
  endproperty
  a_disturb: assert property (p_disturb) else $error("pointers not reset");
  property p_pair;
    s_no_follow |=> pair_err_r && st_r == mpc_pkg::ST_IDLE;
  endproperty
  a_pair: assert property (p_pair) else $error("missing follow-up not flagged");
endmodule : multi_purpose_training_command
`default_nettype wire

/* File: sim/mpc_ctrl_model.sv */
// Purpose: Controller model driving the command pins of the block
// Assumes: One link edge lasts eight pclk periods; the link clock rests low between frames
// Notes: Deselect edges carry the inverse of the last pattern, never a stale value
`timescale 1ns/1ns
`default_nettype none
module mpc_ctrl_model (
  // Clock of the bench
  input wire logic pclk,
  // Command pins
  output logic ck_pin,
  output logic cke_pin,
  output logic cs_pin,
  output logic [5:0] cmd_addr_bus
);
  // Pins idle with clock enable high
  initial begin
    ck_pin = 1'b0;
    cke_pin = 1'b1;
    cs_pin = 1'b0;
    cmd_addr_bus = 6'h2a;
  end
  // One link edge of 400 ns: pins settle 100 ns before the rise, clock high 200 ns
  task automatic edge_out(input logic cs, input logic [5:0] ca);
    repeat (2) @(posedge pclk);
    cs_pin <= cs;
    cmd_addr_bus <= ca;
    repeat (2) @(posedge pclk);
    ck_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    ck_pin <= 1'b0;
  endtask : edge_out
  // Two-edge command, operand split across the edges
  task automatic mpc(input logic [6:0] op);
    edge_out(1'b1, {op[6], 5'h00});
    edge_out(1'b0, op[5:0]);
  endtask : mpc
  // Column follow-up straight after the transfer command, operands low
  task automatic cas2();
    cmd1(mpc_pkg::CA_CAS2);
  endtask : cas2
  // Any other two-edge command with a zero second edge
  task automatic cmd1(input logic [4:0] code);
    edge_out(1'b1, {1'b0, code});
    edge_out(1'b0, 6'h00);
  endtask : cmd1
  // Deselect edges that let the latency counters run
  task automatic idle(input int n);
    repeat (n) edge_out(1'b0, ~cmd_addr_bus);
  endtask : idle
  // Turnaround with latencies of 2: 2 + 1 + 8 + 1 + 8 edges covers every case
  task automatic gap();
    idle(20);
  endtask : gap
  // One deselect edge with clock enable low
  task automatic cke_drop();
    cke_pin <= 1'b0;
    edge_out(1'b0, ~cmd_addr_bus);
    cke_pin <= 1'b1;
  endtask : cke_drop
endmodule : mpc_ctrl_model
`default_nettype wire

/* File: sim/multi_purpose_training_command_tb_top.sv */
// Purpose: Self-checking bench of the multi-purpose command block
// Assumes: Latencies set to two link edges so transfers finish quickly
// Notes: A queue model of the training FIFO predicts every FIFO read burst
`timescale 1ns/1ns
`default_nettype none
module multi_purpose_training_command_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, zq_busy = 1'b0;
  logic ck_pin, cke_pin, cs_pin, osc_start, osc_stop, zq_start, zq_latch;
  logic [5:0] cmd_addr_bus;
  logic [15:0] osc_count = 16'h0, lf = 16'h0026, pat, oc;
  logic [127:0] fifo_wr_data = '0, rd_burst_data, mem [5], v;
  logic wr_capture, rd_launch, rd_is_calib, mask_inversion_drive;
  logic [4:0] burst_beats;
  logic [127:0] rq [$], eq [$];
  int err_count = 0, checks_done = 0, wp = 0, rp = 0;
  int n_os = 0, n_op = 0, n_zs = 0, n_zl = 0, n_wc = 0, n_mi = 0;
  logic [6:0] ops [8] = '{7'h3f, mpc_pkg::OP_OSC_START, 7'h45, mpc_pkg::OP_OSC_STOP,
    7'h49, mpc_pkg::OP_ZQ_START, mpc_pkg::OP_ZQ_START, mpc_pkg::OP_ZQ_LATCH};
  // 20 MHz clock
  always #25 pclk = ~pclk;
  multi_purpose_training_command DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ck_pin, .cke_pin, .cs_pin, .cmd_addr_bus,
    .osc_count, .zq_busy, .osc_start, .osc_stop, .zq_start, .zq_latch, .fifo_wr_data,
    .wr_capture, .rd_launch, .rd_is_calib, .mask_inversion_drive, .rd_burst_data,
    .burst_beats);
  mpc_ctrl_model CTL (.pclk, .ck_pin, .cke_pin, .cs_pin, .cmd_addr_bus);
  // Pulse counters and capture of every launched burst
  always @(posedge pclk) begin
    n_os += (osc_start === 1'b1);
    n_op += (osc_stop === 1'b1);
    n_zs += (zq_start === 1'b1);
    n_zl += (zq_latch === 1'b1);
    n_wc += (wr_capture === 1'b1);
    n_mi += (mask_inversion_drive === 1'b1);
    if (rd_launch === 1'b1) rq.push_back(rd_burst_data);
  end
  // Shift register source of random data
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic check(input string nm, input logic [127:0] e, input logic [127:0] s);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic cnt(input string nm, input int e, input int s);
    check(nm, 128'(e), 128'(s));
  endtask : cnt
  // APB transfer: hold the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait that never sees pready
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // Watchdog well beyond the expected run of about 70 us
  initial begin
    #2000000;
    err_count++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, mpc_pkg::ADDR_CFG, 32'h0);
    check("cfg reset", mpc_pkg::CFG_RESET, rd);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped err", 1'b1, er);
    lf = lfsr(lf);
    pat = lf;
    apb(1'b1, mpc_pkg::ADDR_CFG, 32'h0004_0202);
    apb(1'b1, mpc_pkg::ADDR_PAT, {16'h0, pat});
    check("burst beats", mpc_pkg::TRAIN_BEATS, burst_beats);
    $display("test registers done");
    // Non-transfer functions, reserved codes and a start while calibration runs
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      osc_count <= lf;
      if (ops[i] == mpc_pkg::OP_OSC_STOP) oc = lf;
      zq_busy <= (i == 6);
      CTL.mpc(ops[i]);
      CTL.idle(1);
    end
    cnt("osc start", 1, n_os);
    cnt("osc stop", 1, n_op);
    cnt("zq start", 1, n_zs);
    cnt("zq latch", 1, n_zl);
    cnt("no transfer", 0, n_wc + rq.size());
    apb(1'b0, mpc_pkg::ADDR_OSC, 32'h0);
    check("osc count", {16'h0, oc}, rd);
    $display("test single commands done");
    // Six writes: the sixth lands on the first entry
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 8; k++) begin
        lf = lfsr(lf);
        v[16*k +: 16] = lf;
      end
      fifo_wr_data <= v;
      mem[wp] = v;
      wp = (wp + 1) % 5;
      CTL.mpc(mpc_pkg::OP_WR_FIFO);
      CTL.cas2();
      CTL.idle(3);
    end
    cnt("write captures", 6, n_wc);
    // Seven seamless reads: the pointer wraps after five
    for (int i = 0; i < 7; i++) begin
      eq.push_back(mem[rp]);
      rp = (rp + 1) % 5;
      CTL.mpc(mpc_pkg::OP_RD_FIFO);
      CTL.cas2();
    end
    CTL.gap();
    cnt("read launches", 7, rq.size());
    while (rq.size() > 0 && eq.size() > 0) check("fifo data", eq.pop_front(),
      rq.pop_front());
    cnt("mask drive", 7, n_mi);
    apb(1'b0, mpc_pkg::ADDR_STAT, 32'h0);
    check("pointers", {2'b00, 3'(rp), 1'b0, 3'(wp)}, rd[8:0]);
    $display("test fifo done");
    // A normal read disturbs both pointers
    CTL.cmd1(mpc_pkg::CA_RD1);
    CTL.gap();
    apb(1'b0, mpc_pkg::ADDR_STAT, 32'h0);
    check("pointers cleared", 7'h0, rd[6:0]);
    // Pattern read: beat b is pattern bit b on all eight pins
    for (int b = 0; b < 16; b++) v[8*b +: 8] = {8{pat[b]}};
    CTL.mpc(mpc_pkg::OP_RD_CAL);
    CTL.cas2();
    CTL.gap();
    cnt("pattern launch", 1, rq.size());
    if (rq.size() > 0) check("pattern data", v, rq.pop_front());
    check("calib flag", 1'b1, rd_is_calib);
    cnt("no mask on pattern", 7, n_mi);
    $display("test pattern done");
    // A transfer with no follow-up is dropped and flagged
    CTL.mpc(mpc_pkg::OP_WR_FIFO);
    CTL.idle(1);
    CTL.mpc(mpc_pkg::OP_WR_FIFO);
    CTL.cas2();
    CTL.idle(3);
    cnt("write after drop", 7, n_wc);
    apb(1'b0, mpc_pkg::ADDR_STAT, 32'h0);
    check("pairing flag", 9'h101, rd[8:0]);
    // Clear the flag, then clock enable low clears both pointers
    apb(1'b1, mpc_pkg::ADDR_STAT, 32'h0000_0100);
    CTL.cke_drop();
    apb(1'b0, mpc_pkg::ADDR_STAT, 32'h0);
    check("cke clears", 9'h000, rd[8:0]);
    $display("test pairing and clock enable done");
    end_sim();
  end
endmodule : multi_purpose_training_command_tb_top
`default_nettype wire
